// ==== acs_pkg.sv ====
// Purpose: Shared constants for the amplifier control two-wire link.
// Assumes: 40 MHz system clock on both ends.
// Notes: Bus addresses, subaddress layout and host bit timing.
package acs_pkg;
    localparam logic [4:0] ACS_ADDR_BASE = 5'h1B;   // Upper five bits of all four addresses.
    localparam int ACS_SUB_INC_BIT = 7;             // Auto-increment flag position.
    localparam int ACS_SUB_IDX_MSB = 4;             // Register index top bit.
    localparam int ACS_REG_COUNT = 32;              // Index space of the five-bit field.
    localparam int ACS_DEF_REGS = 20;               // Defined registers, others read as all ones.
    localparam logic [7:0] ACS_UNDEF_DATA = 8'hFF;
    localparam logic [7:0] ACS_REG_RESET = 8'h00;
    localparam int ACS_CLK_HZ = 40000000;
    localparam int ACS_MAX_BIT_HZ = 400000;
    // Cycles per quarter of one bus bit; rounds up so the rate never exceeds the limit.
    localparam int ACS_QUARTER_CYC = (ACS_CLK_HZ + 4 * ACS_MAX_BIT_HZ - 1) / (4 * ACS_MAX_BIT_HZ);
    localparam int ACS_BITS_PER_BYTE = 8;
endpackage

// ==== acs_link_if.sv ====
// Purpose: Two open-drain wires joining host and device ends.
// Assumes: External pull-ups, modelled as wired-AND of releases.
// Notes: Output enable low means the party pulls the wire low.
`timescale 1ns/1ps
interface acs_link_if;
    logic scl_oe_n_host;
    logic sda_oe_n_host;
    logic sda_oe_n_dev;
    logic scl;
    logic sda;
    assign scl = scl_oe_n_host;
    assign sda = sda_oe_n_host & sda_oe_n_dev;
    modport host (output scl_oe_n_host, output sda_oe_n_host, input scl, input sda);
    modport dev (output sda_oe_n_dev, input scl, input sda);
endinterface

// ==== acs_slave.sv ====
// Purpose: Device end: two-wire slave holding the amplifier control registers.
// Assumes: Bus wires are asynchronous and are synchronised before use.
// Notes: Writes are kept while the audio clock is absent and applied when it runs.
`timescale 1ns/1ps
// Function
// - Two open-drain wires carry all traffic.
// - Host sends start, address, subaddress, data, stop.
// - Answer to four addresses 1101100 to 1101111; this device answers only the one chosen by addr_sel.
// - Write bit zero makes device receive.
// - Increment flag advances pointer per byte.
// - Without increment only one register written.
// - With increment, consecutive registers until stop or last.
// - Reads start at last addressed register.
// - Host sets pointer with write before read.
// - Host ends read with no-ack, stop.
// - Repeated start accepted instead of stop-start.
// - Flag clear: read repeats one register.
// - Flag set: read walks consecutive registers.
// - Undefined registers read as 0xFF.
// - Data changes only while clock low.
// - Start and stop detected with clock high.
// - Eight bits, MSB first, then acknowledge.
// - Receiver pulls acknowledge low.
// - Host stays at or below 400 kbit/s.
// - Subaddress is flag, two zeros, five-bit index.
// - Writes held until audio clock present.
// - Host waits for audio clock before programming; the bench writes register 4 with audio low.
module acs_slave
    import acs_pkg::*;
#(
    parameter int NUM_REGS = ACS_DEF_REGS
)
(
    input wire logic clk_sys,
    input wire logic rst,
    acs_link_if.dev link,
    input wire logic [1:0] addr_sel,
    input wire logic audio_clk_present,
    output logic [NUM_REGS*8-1:0] cfg_regs,
    input wire logic [NUM_REGS*8-1:0] stat_regs,
    input wire logic [NUM_REGS-1:0] stat_mask
);
    // Refuse register counts that the five-bit index cannot reach.
    if (NUM_REGS < 1 || NUM_REGS > ACS_REG_COUNT)
    begin : g_num_regs_check
        $error("NUM_REGS out of range");
    end

    typedef enum {ST_IDLE, ST_ADDR, ST_SUB, ST_WDATA, ST_RDATA, ST_IGNORE} acs_state_t;

    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic scl_prev_reg;
    logic sda_prev_reg;
    acs_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [4:0] ptr_reg;
    logic inc_reg;
    logic ack_phase_reg;
    logic sda_oe_n_reg;
    logic [1:0] audio_sync_reg;
    logic [7:0] pend_reg [NUM_REGS];
    logic [NUM_REGS-1:0] pend_dirty_reg;
    logic [7:0] live_reg [NUM_REGS];
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic [7:0] rd_byte;
    logic wr_en;

    // Two flops on each wire and on the audio clock flag, which come from other domains.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            audio_sync_reg <= 2'h0;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], link.scl};
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
            audio_sync_reg <= {audio_sync_reg[0], audio_clk_present};
        end
    end

    // Edge and condition detection on the synchronised wires.
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
    assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

    // Read data comes from live status where masked in, else stored config.
    always_comb
    begin
        rd_byte = ACS_UNDEF_DATA;
        if (int'(ptr_reg) < NUM_REGS)
            rd_byte = stat_mask[ptr_reg] ? stat_regs[ptr_reg*8 +: 8] : pend_reg[ptr_reg];
    end

    // Protocol sequencer; bits sampled on the rising clock edge.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 5'h00;
            inc_reg <= 1'b0;
            ack_phase_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end
        else if (start_det)
        begin
            state_reg <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            ack_phase_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end
        else if (stop_det)
        begin
            state_reg <= ST_IDLE;
            sda_oe_n_reg <= 1'b1;
        end
        else if (scl_rise && state_reg != ST_IDLE && state_reg != ST_IGNORE)
        begin
            if (ack_phase_reg)
            begin
                if (state_reg == ST_RDATA && sda_s)
                    state_reg <= ST_IGNORE;
            end
            else
            begin
                shift_reg <= {shift_reg[6:0], sda_s};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
        else if (scl_fall && state_reg != ST_IDLE && state_reg != ST_IGNORE)
        begin
            if (ack_phase_reg)
            begin
                // End of acknowledge slot: release and prepare next byte.
                ack_phase_reg <= 1'b0;
                bit_cnt_reg <= 4'h0;
                sda_oe_n_reg <= 1'b1;
                if (state_reg == ST_RDATA)
                begin
                    sda_oe_n_reg <= rd_byte[7];
                    shift_reg <= rd_byte;
                end
            end
            else if (bit_cnt_reg == 4'(ACS_BITS_PER_BYTE))
            begin
                ack_phase_reg <= 1'b1;
                sda_oe_n_reg <= 1'b0;
                case (state_reg)
                    ST_ADDR:
                    begin
                        if (shift_reg[7:3] != ACS_ADDR_BASE || shift_reg[2:1] != addr_sel)
                        begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= ST_IGNORE;
                        end
                        else if (!shift_reg[0])
                            state_reg <= ST_SUB;
                        else
                        begin
                            state_reg <= ST_RDATA; // Address still acknowledged.
                        end
                    end
                    ST_SUB:
                    begin
                        inc_reg <= shift_reg[ACS_SUB_INC_BIT];
                        ptr_reg <= shift_reg[ACS_SUB_IDX_MSB:0];
                        state_reg <= ST_WDATA;
                    end
                    ST_WDATA:
                    begin
                        if (inc_reg && int'(ptr_reg) < NUM_REGS - 1)
                            ptr_reg <= ptr_reg + 5'h1;
                    end
                    ST_RDATA:
                    begin
                        // Host acknowledges; device releases for it.
                        sda_oe_n_reg <= 1'b1;
                        if (inc_reg)
                            ptr_reg <= ptr_reg + 5'h1;
                    end
                    default:
                        state_reg <= ST_IGNORE;
                endcase
            end
            else if (state_reg == ST_RDATA)
            begin
                sda_oe_n_reg <= shift_reg[7]; // Shifted on each rise, so the top bit is next.
            end
        end
    end

    assign wr_en = scl_fall && !ack_phase_reg && state_reg == ST_WDATA
        && bit_cnt_reg == 4'(ACS_BITS_PER_BYTE) && int'(ptr_reg) < NUM_REGS;

    // Per-register pending store and audio-clock gated apply.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++)
        begin : g_reg
            always_ff @(posedge clk_sys)
            begin
                if (rst)
                begin
                    pend_reg[gi] <= ACS_REG_RESET;
                    live_reg[gi] <= ACS_REG_RESET;
                    pend_dirty_reg[gi] <= 1'b0;
                end
                else
                begin
                    if (wr_en && int'(ptr_reg) == gi)
                    begin
                        pend_reg[gi] <= shift_reg;
                        pend_dirty_reg[gi] <= 1'b1;
                    end
                    else if (audio_sync_reg[1] && pend_dirty_reg[gi])
                    begin
                        live_reg[gi] <= pend_reg[gi];
                        pend_dirty_reg[gi] <= 1'b0;
                    end
                end
            end
            assign cfg_regs[gi*8 +: 8] = live_reg[gi];
        end
    endgenerate

    assign link.sda_oe_n_dev = sda_oe_n_reg;
endmodule // acs_slave

// ==== acs_master.sv ====
// Purpose: Host end: issues write and read transactions to the slave.
// Assumes: Single master; no clock stretching by the slave.
// Notes: Each bit spans four quarter periods; rate stays at or under the limit.
`timescale 1ns/1ps
module acs_master
    import acs_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    acs_link_if.host link,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_read,
    input wire logic cmd_rstart,
    input wire logic [6:0] cmd_dev_addr,
    input wire logic [7:0] cmd_subaddr,
    input wire logic [7:0] cmd_wdata,
    input wire logic [3:0] cmd_len,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic nack_err
);
    typedef enum {M_IDLE, M_START, M_BYTE, M_STOP} acs_mstate_t;

    acs_mstate_t st_reg;
    logic [1:0] scl_sync_reg;
    logic [1:0] sda_sync_reg;
    logic [15:0] qcnt_reg;
    logic [1:0] phase_reg;
    logic [3:0] bit_reg;
    logic [8:0] tx_reg;
    logic [7:0] rx_reg;
    logic [3:0] byte_idx_reg;
    logic [3:0] len_reg;
    logic read_reg;
    logic rstart_reg;
    logic rphase_reg;
    logic [6:0] dev_reg;
    logic [7:0] sub_reg;
    logic [7:0] wdata_reg;
    logic scl_reg;
    logic sda_reg;
    logic tick;

    // Wires sampled through two flops.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
        end
        else
        begin
            scl_sync_reg <= {scl_sync_reg[0], link.scl};
            sda_sync_reg <= {sda_sync_reg[0], link.sda};
        end
    end

    assign tick = (qcnt_reg == 16'(ACS_QUARTER_CYC - 1));
    always_ff @(posedge clk_sys)
    begin
        if (rst || st_reg == M_IDLE)
            qcnt_reg <= 16'h0000;
        else
            qcnt_reg <= tick ? 16'h0000 : qcnt_reg + 16'h0001;
    end

    assign cmd_ready = (st_reg == M_IDLE);

    // Transaction sequencer; data bits change in quarter 0 while clock low, start and stop move data in quarter 2.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_reg <= M_IDLE;
            phase_reg <= 2'h0;
            bit_reg <= 4'h0;
            tx_reg <= 9'h1FF;
            rx_reg <= 8'h00;
            byte_idx_reg <= 4'h0;
            len_reg <= 4'h0;
            read_reg <= 1'b0;
            rstart_reg <= 1'b0;
            rphase_reg <= 1'b0;
            dev_reg <= 7'h00;
            sub_reg <= 8'h00;
            wdata_reg <= 8'h00;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            nack_err <= 1'b0;
        end
        else
        begin
            rd_valid <= 1'b0;
            case (st_reg)
                M_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        read_reg <= cmd_read;
                        rstart_reg <= cmd_rstart;
                        rphase_reg <= 1'b0;
                        dev_reg <= cmd_dev_addr;
                        sub_reg <= cmd_subaddr;
                        wdata_reg <= cmd_wdata;
                        len_reg <= cmd_len;
                        nack_err <= 1'b0;
                        phase_reg <= 2'h0;
                        st_reg <= M_START;
                    end
                end
                M_START:
                begin
                    if (tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        // start: SDA falls with SCL high
                        case (phase_reg)
                            2'h0: sda_reg <= 1'b1;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: sda_reg <= 1'b0;
                            default:
                            begin
                                scl_reg <= 1'b0;
                                tx_reg <= {dev_reg, read_reg & ~rstart_reg | rphase_reg, 1'b1};
                                bit_reg <= 4'h0;
                                byte_idx_reg <= 4'h0;
                                st_reg <= M_BYTE;
                            end
                        endcase
                    end
                end
                M_BYTE:
                begin
                    if (tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        case (phase_reg)
                            2'h0: sda_reg <= tx_reg[8];
                            2'h1: scl_reg <= 1'b1;
                            2'h2:
                            begin
                                if (bit_reg < 4'h8)
                                    rx_reg <= {rx_reg[6:0], sda_sync_reg[1]};
                                // Own no-ack on a read byte is not a device fault.
                                else if (tx_reg[8] && sda_sync_reg[1] && !((rphase_reg
                                    || (read_reg && !rstart_reg)) && byte_idx_reg != 4'h0))
                                    nack_err <= 1'b1;
                            end
                            default:
                            begin
                                scl_reg <= 1'b0;
                                tx_reg <= {tx_reg[7:0], 1'b1};
                                bit_reg <= bit_reg + 4'h1;
                                if (bit_reg == 4'h8)
                                begin
                                    bit_reg <= 4'h0;
                                    byte_idx_reg <= byte_idx_reg + 4'h1;
                                    if (rphase_reg || (read_reg && !rstart_reg))
                                    begin
                                        if (byte_idx_reg != 4'h0)
                                        begin
                                            rd_valid <= 1'b1;
                                            rd_data <= rx_reg;
                                        end
                                        tx_reg <= {8'hFF, 1'b1};
                                        if (byte_idx_reg + 4'h1 == len_reg)
                                            tx_reg <= {8'hFF, 1'b1};
                                        else
                                            tx_reg <= {8'hFF, 1'b0};
                                        if (byte_idx_reg == len_reg || nack_err)
                                            st_reg <= M_STOP;
                                    end
                                    else if (byte_idx_reg == 4'h0)
                                        tx_reg <= {sub_reg, 1'b1};
                                    else if (byte_idx_reg == 4'h1 && rstart_reg)
                                    begin
                                        rphase_reg <= 1'b1;
                                        st_reg <= M_START;
                                    end
                                    else if (byte_idx_reg >= len_reg || nack_err)
                                        st_reg <= M_STOP;
                                    else
                                        tx_reg <= {wdata_reg, 1'b1};
                                end
                            end
                        endcase
                    end
                end
                M_STOP:
                begin
                    if (tick)
                    begin
                        phase_reg <= phase_reg + 2'h1;
                        case (phase_reg)
                            2'h0: sda_reg <= 1'b0;
                            2'h1: scl_reg <= 1'b1;
                            2'h2: sda_reg <= 1'b1;
                            default: st_reg <= M_IDLE;
                        endcase
                    end
                end
                default: st_reg <= M_IDLE;
            endcase
        end
    end

    assign link.scl_oe_n_host = scl_reg;
    assign link.sda_oe_n_host = sda_reg;
endmodule // acs_master

// ==== acs_link_monitor.sv ====
// Purpose: Protocol checker for the two-wire link between host and device ends.
// Assumes: One clock domain; the wires are sampled directly on clk_sys.
// Notes: DEV_ADDR must match the address that the device end was strapped to.
`timescale 1ns/1ps
module acs_link_monitor #(
    parameter logic [6:0] DEV_ADDR = 7'h6C
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_oe_n_dev
);
    logic scl_d_reg, sda_d_reg, idle_reg;
    logic [3:0] bit_cnt_reg;
    logic [1:0] byte_n_reg;
    logic [7:0] sh_reg, addr_reg, gap_reg;
    logic scl_rise, sel, ack_slot;
    // Delayed copies give edges without sampled-value calls in plain logic.
    assign scl_rise = scl & ~scl_d_reg;
    assign sel = addr_reg[7:1] == DEV_ADDR;
    assign ack_slot = scl_rise && bit_cnt_reg == 4'h8;
    // Frame tracker: start clears the count, stop marks the bus idle.
    always_ff @(posedge clk_sys)
    begin
        scl_d_reg <= scl;
        sda_d_reg <= sda;
        if (rst)
        begin
            idle_reg <= 1'b1;
            bit_cnt_reg <= 4'h0;
            byte_n_reg <= 2'h0;
        end
        else if (scl && scl_d_reg && sda_d_reg && !sda)
        begin
            idle_reg <= 1'b0;
            bit_cnt_reg <= 4'h0;
            byte_n_reg <= 2'h0;
        end
        else if (scl && scl_d_reg && !sda_d_reg && sda)
            idle_reg <= 1'b1;
        else if (ack_slot)
        begin
            bit_cnt_reg <= 4'h0;
            byte_n_reg <= byte_n_reg + {1'b0, byte_n_reg != 2'h3};
            if (byte_n_reg == 2'h0)
                addr_reg <= sh_reg;
        end
        else if (scl_rise)
        begin
            sh_reg <= {sh_reg[6:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end
    // Cycles since the last clock rise; saturates so that the first rise passes.
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            gap_reg <= 8'hFF;
        else if (scl_rise)
            gap_reg <= 8'h00;
        else if (gap_reg != 8'hFF)
            gap_reg <= gap_reg + 8'h01;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_dev_scl_low; !$stable(sda_oe_n_dev) |-> !scl; endproperty
    a_dev_scl_low: assert property (p_dev_scl_low)
        else $error("device moved data while clock high");
    property p_addr_ack; ack_slot && byte_n_reg == 2'h0 |-> sda_oe_n_dev == (sh_reg[7:1] != DEV_ADDR);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("address acknowledge wrong");
    property p_write_ack; ack_slot && byte_n_reg != 2'h0 && sel && !addr_reg[0] |-> !sda_oe_n_dev;
    endproperty
    a_write_ack: assert property (p_write_ack)
        else $error("written byte not acknowledged");
    property p_read_release; ack_slot && byte_n_reg != 2'h0 && addr_reg[0] |-> sda_oe_n_dev;
    endproperty
    a_read_release: assert property (p_read_release)
        else $error("device held data in host acknowledge slot");
    property p_rx_quiet; scl_rise && !ack_slot && (byte_n_reg == 2'h0 || !addr_reg[0])
        |-> sda_oe_n_dev; endproperty
    a_rx_quiet: assert property (p_rx_quiet)
        else $error("device drove a bit it should receive");
    property p_unsel_quiet; byte_n_reg != 2'h0 && !sel && !idle_reg |-> sda_oe_n_dev; endproperty
    a_unsel_quiet: assert property (p_unsel_quiet)
        else $error("device active on foreign address");
    property p_idle_quiet; idle_reg |-> sda_oe_n_dev; endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("device drove data after stop");
    property p_scl_rate; scl_rise |-> gap_reg >= 8'h63; endproperty
    a_scl_rate: assert property (p_scl_rate)
        else $error("bus clock faster than allowed");
endmodule // acs_link_monitor

// ==== tb.sv ====
// Purpose: Self-checking bench joining host and device ends over the link.
// Assumes: Both ends share clk_sys; only the device strap address answers.
// Notes: Write lengths count the subaddress; reads ask one byte more than checked.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb;
    import acs_pkg::*;
    localparam logic [1:0] SEL = 2'h1;
    localparam logic [6:0] DEV = {ACS_ADDR_BASE, SEL};
    localparam int TIME_CAP = 95000;
    logic clk_sys = 1'b0;
    logic rst, cmd_valid, cmd_ready, cmd_read, cmd_rstart, rd_valid, nack_err, audio;
    logic [6:0] cmd_dev_addr;
    logic [7:0] cmd_subaddr, cmd_wdata, rd_data;
    logic [3:0] cmd_len;
    logic [8*ACS_DEF_REGS-1:0] cfg_regs, stat_regs;
    logic [ACS_DEF_REGS-1:0] stat_mask;
    logic [7:0] rq[$];
    int n_errors, n_compared, cycles;
    acs_link_if acs_link_if_inst();
    acs_slave acs_slave_inst(.clk_sys(clk_sys), .rst(rst), .link(acs_link_if_inst.dev),
        .addr_sel(SEL), .audio_clk_present(audio), .cfg_regs(cfg_regs),
        .stat_regs(stat_regs), .stat_mask(stat_mask));
    acs_master acs_master_inst(.clk_sys(clk_sys), .rst(rst), .link(acs_link_if_inst.host),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_read(cmd_read),
        .cmd_rstart(cmd_rstart), .cmd_dev_addr(cmd_dev_addr), .cmd_subaddr(cmd_subaddr),
        .cmd_wdata(cmd_wdata), .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_data(rd_data),
        .nack_err(nack_err));
    acs_link_monitor #(.DEV_ADDR(DEV)) acs_link_monitor_inst(.clk_sys(clk_sys), .rst(rst),
        .scl(acs_link_if_inst.scl), .sda(acs_link_if_inst.sda),
        .sda_oe_n_dev(acs_link_if_inst.sda_oe_n_dev));
    // Half-period toggle gives the 40 MHz system clock.
    always #12.5 clk_sys = ~clk_sys;
    // Read bytes are collected at the falling edge, where the pulse is settled.
    always @(negedge clk_sys)
        if (rd_valid === 1'b1)
            rq.push_back(rd_data);
    // A hung transfer must not stall the run forever.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == TIME_CAP)
        begin
            n_errors++;
            give_verdict();
        end
    end
    function automatic logic [7:0] reg_at(input int i);
        return cfg_regs[i*8 +: 8];
    endfunction
    task automatic give_verdict();
        if (n_errors == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One command, held for the single edge it is taken on, then waited out.
    task automatic run(input logic rd, input logic rs, input logic [6:0] a,
        input logic [7:0] s, input logic [7:0] w, input logic [3:0] n);
        int k;
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1)
            @(negedge clk_sys);
        {cmd_read, cmd_rstart, cmd_dev_addr, cmd_subaddr, cmd_wdata} = {rd, rs, a, s, w};
        cmd_len = n;
        cmd_valid = 1'b1;
        rq.delete();
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        for (k = 0; k < 20000 && cmd_ready !== 1'b1; k++)
            @(negedge clk_sys);
    endtask
    task automatic rd_chk(input logic [7:0] e0, input logic [7:0] e1);
        `CHK("rd0", e0, rq[0])
        `CHK("rd1", e1, rq[1])
        `CHK("rd_nack", 1'b0, nack_err)
    endtask
    // Main sequence of transfers with expected register and read-back values.
    initial
    begin
        int i;
        int k;
        logic [6:0] a;
        {n_errors, n_compared, cycles} = '0;
        {rst, audio} = 2'h3;
        {cmd_valid, cmd_read, cmd_rstart, cmd_dev_addr, cmd_subaddr, cmd_wdata, cmd_len} = '0;
        stat_regs = '0;
        stat_mask = '0;
        stat_regs[10*8 +: 16] = 16'hC2C1;
        stat_mask[11:10] = 2'h3;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        run(1'b0, 1'b0, DEV, 8'h02, 8'h3C, 4'h2);
        `CHK("reg2", 8'h3C, reg_at(2))
        `CHK("reg3", 8'h00, reg_at(3))
        run(1'b1, 1'b0, DEV, 8'h00, 8'h00, 4'h3);
        rd_chk(8'h3C, 8'h3C);
        run(1'b1, 1'b1, DEV, 8'h8A, 8'h00, 4'h3);
        rd_chk(8'hC1, 8'hC2);
        run(1'b1, 1'b1, DEV, 8'h14, 8'h00, 4'h3);
        rd_chk(8'hFF, 8'hFF);
        run(1'b0, 1'b0, DEV, 8'h85, 8'h5A, 4'h4);
        for (i = 4; i < 9; i++)
            `CHK("reg_inc", (i > 4 && i < 8) ? 8'h5A : 8'h00, reg_at(i))
        run(1'b0, 1'b0, DEV, 8'h92, 8'h77, 4'h3);
        `CHK("reg19", 8'h77, reg_at(19))
        `CHK("reg0", 8'h00, reg_at(0))
        audio = 1'b0;
        run(1'b0, 1'b0, DEV, 8'h04, 8'h99, 4'h2);
        `CHK("reg4_held", 8'h00, reg_at(4))
        audio = 1'b1;
        for (k = 0; k < 10 && reg_at(4) !== 8'h99; k++)
            @(negedge clk_sys);
        `CHK("reg4_applied", 8'h99, reg_at(4))
        for (i = 0; i < 5; i++)
        begin
            a = (i < 4) ? {ACS_ADDR_BASE, 2'(i)} : 7'h50;
            run(1'b0, 1'b0, a, 8'h03, 8'(16 + i), 4'h2);
            `CHK("nack", a != DEV, nack_err)
            `CHK("reg3", (i >= 1) ? 8'h11 : 8'h00, reg_at(3))
        end
        give_verdict();
    end
endmodule // tb
